// [phs_highway.sv]
// Behaviour
// - outputs enabled only after three frames
// - startup: signaling low, data and slot tri-stated
// - signaling input ignored during startup
// - master clock stopped: data, slot tri-stated
// - first bit on first rising edge after sync
// - receive bits sampled on falling bit-clock edge
// - fixed rate, variable rate, on-line test modes
// - each bit held one bit-clock period
// - first sample: falling edge after receive sync
// - redundancy test and analog loopback modes
// - up to 32 devices share one highway
`timescale 1ns/1ps
`default_nettype none
module phs_highway
   import phs_pkg::*;
(
   input  wire logic            clk,              // 100 MHz system clock
   input  wire logic            reset_n,          // synchronous reset
   input  wire logic            clkEn,            // freezes all state when low
   input  wire phs_mode_t       opMode,           // operating mode
   input  wire logic            standby,          // standby power-down request
   input  wire logic            master_clock,     // master clock pin
   input  wire logic            tx_bit_clock,     // transmit bit clock pin
   input  wire logic            tx_frame_sync,    // transmit frame sync pin
   input  wire logic            rx_bit_clock,     // receive bit clock pin
   input  wire logic            rx_frame_sync,    // receive frame sync pin
   input  wire logic            rx_pcm_data,      // receive highway pin
   input  wire logic            signaling_in,     // signaling input pin
   input  wire logic            sigInsert,        // force word LSB high while signaling is high
   output logic                 sigOut,           // signaling output
   output logic                 tx_pcm_data,      // transmit highway data
   output logic                 txDataOe,         // transmit highway drive enable
   output logic                 tx_slot_indicator,// slot indicator, high in slot
   output logic                 txSlotOe,         // slot indicator drive enable
   input  wire logic [7:0]      txWord,           // word to queue
   input  wire logic            txWordValid,      // queue request
   output logic                 txWordReady,      // queue has room
   output logic [7:0]           rxWord,           // last received word
   output logic                 rxWordValid,      // one-cycle pulse per word
   output logic                 outputsLive       // startup interval over
);
   // two-flop synchronisers, then one delay stage for edge finding
   logic [PHS_SYNC_BITS-1:0] meta1Reg;
   logic [PHS_SYNC_BITS-1:0] syncReg;
   logic [PHS_SYNC_BITS-1:0] prevReg;
   wire  [PHS_SYNC_BITS-1:0] pinVec;

   assign pinVec = {signaling_in, rx_pcm_data, rx_frame_sync, rx_bit_clock,
                    tx_frame_sync, tx_bit_clock, master_clock};

   genvar gi;
   generate
      for (gi = 0; gi < PHS_SYNC_BITS; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               meta1Reg[gi] <= 1'b0;
               syncReg[gi]  <= 1'b0;
               prevReg[gi]  <= 1'b0;
            end else if (clkEn) begin
               meta1Reg[gi] <= pinVec[gi];
               syncReg[gi]  <= meta1Reg[gi];
               prevReg[gi]  <= syncReg[gi];
            end
         end
      end
   endgenerate

   // clock selection and edges
   wire fixedRate = (opMode == PHS_FIXED_RATE);
   wire txClkSel  = fixedRate ? syncReg[PHS_S_MCLK] : syncReg[PHS_S_TCLK];
   wire txClkPrev = fixedRate ? prevReg[PHS_S_MCLK] : prevReg[PHS_S_TCLK];
   wire rxClkSel  = fixedRate ? syncReg[PHS_S_MCLK] : syncReg[PHS_S_RCLK];
   wire rxClkPrev = fixedRate ? prevReg[PHS_S_MCLK] : prevReg[PHS_S_RCLK];
   wire txRise    = txClkSel && !txClkPrev;
   wire rxFall    = !rxClkSel && rxClkPrev;
   wire mclkEdge  = syncReg[PHS_S_MCLK] != prevReg[PHS_S_MCLK];
   wire txFsRise  = syncReg[PHS_S_TFS] && !prevReg[PHS_S_TFS];
   wire rxFsRise  = syncReg[PHS_S_RFS] && !prevReg[PHS_S_RFS];

   // master clock watchdog
   logic [7:0] stopCntReg;
   logic       mclkStoppedReg;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stopCntReg     <= 8'h00;
         mclkStoppedReg <= 1'b1;
      end else if (clkEn) begin
         if (mclkEdge) begin
            stopCntReg     <= 8'h00;
            mclkStoppedReg <= 1'b0;
         end else if (stopCntReg == PHS_STOP_CNT_MAX) begin
            mclkStoppedReg <= 1'b1;
         end else begin
            stopCntReg <= stopCntReg + 8'h01;
         end
      end
   end

   // startup frame counter, restarted by standby
   logic [1:0] frmCntReg;
   wire        liveNow = (frmCntReg == PHS_FRM_DONE);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         frmCntReg <= PHS_FRM_RST;
      end else if (clkEn) begin
         if (standby) begin
            frmCntReg <= PHS_FRM_RST;
         end else if (txFsRise && !liveNow) begin
            frmCntReg <= frmCntReg + 2'h1;
         end
      end
   end
   assign outputsLive = liveNow;

   // signaling is forced low and unused until live
   wire sigLive = liveNow && syncReg[PHS_S_SIG];
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sigOut <= 1'b0;
      end else if (clkEn) begin
         sigOut <= sigLive;
      end
   end

   // transmit word queue
   logic [7:0] qData;
   logic       qValid;
   logic       qPop;
   phs_fifo #(.WIDTH(PHS_WORD_BITS), .DEPTH(PHS_FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .inData   (txWord),
      .inValid  (txWordValid),
      .inReady  (txWordReady),
      .outData  (qData),
      .outValid (qValid),
      .outReady (qPop)
   );

   // transmit slot machine
   typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} phs_tx_state_t;
   phs_tx_state_t txStateReg;
   phs_tx_state_t txStateNext;
   logic [7:0]    txShiftReg;
   logic [7:0]    lastTxReg;
   logic [3:0]    txBitReg;
   logic          txDrvReg;
   logic [7:0]    rxWordReg;

   // word source per mode
   wire        normalMode = (opMode == PHS_FIXED_RATE) || (opMode == PHS_VAR_RATE);
   wire [7:0]  srcWord    = (opMode == PHS_REDUNDANCY)  ? lastTxReg :
                            (opMode == PHS_ANALOG_LOOP) ? rxWordReg :
                            (qValid ? qData : PHS_IDLE_CODE);
   wire [7:0]  loadWord   = {srcWord[7:1], (sigInsert && sigLive) ? 1'b1 : srcWord[0]};
   wire        slotStart  = (txStateReg == TX_ARMED) && txRise && liveNow;
   wire        lastBit    = (txBitReg == PHS_BIT_LAST);
   assign qPop = slotStart && normalMode;

   always_comb begin
      txStateNext = txStateReg;
      unique case (txStateReg)
         TX_IDLE:  if (txFsRise) txStateNext = TX_ARMED;
         TX_ARMED: if (txRise)   txStateNext = liveNow ? TX_SHIFT : TX_IDLE;
         TX_SHIFT: if (txRise && lastBit) txStateNext = TX_IDLE;
      endcase
   end

   // shift out MSB first, one bit per rising edge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         txStateReg <= TX_IDLE;
         txShiftReg <= PHS_WORD_RST;
         lastTxReg  <= PHS_WORD_RST;
         txBitReg   <= 4'h0;
         txDrvReg   <= 1'b0;
      end else if (clkEn) begin
         txStateReg <= txStateNext;
         if (slotStart) begin
            txShiftReg <= loadWord;
            lastTxReg  <= loadWord;
            txBitReg   <= 4'h1;
            txDrvReg   <= 1'b1;
         end else if ((txStateReg == TX_SHIFT) && txRise) begin
            txShiftReg <= {txShiftReg[6:0], 1'b0};
            txBitReg   <= txBitReg + 4'h1;
            if (lastBit) txDrvReg <= 1'b0;
         end
      end
   end

   // highway drive, gated by startup and clock watchdog
   wire driveOk = txDrvReg && liveNow && !mclkStoppedReg && !standby;
   assign tx_pcm_data       = txShiftReg[7];
   assign txDataOe          = driveOk;
   assign tx_slot_indicator = driveOk;
   assign txSlotOe          = liveNow && !mclkStoppedReg && !standby;

   // receive: arm on sync, sample eight falling edges
   logic       rxArmReg;
   logic [3:0] rxBitReg;
   logic [7:0] rxShiftReg;
   wire        rxTake = rxArmReg && rxFall;
   wire [7:0]  rxShiftNext = {rxShiftReg[6:0], syncReg[PHS_S_RDAT]};
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxArmReg    <= 1'b0;
         rxBitReg    <= 4'h0;
         rxShiftReg  <= PHS_WORD_RST;
         rxWordReg   <= PHS_WORD_RST;
         rxWordValid <= 1'b0;
      end else if (clkEn) begin
         rxWordValid <= 1'b0;
         if (rxFsRise) begin
            rxArmReg <= 1'b1;
            rxBitReg <= 4'h0;
         end else if (rxTake) begin
            rxShiftReg <= rxShiftNext;
            rxBitReg   <= rxBitReg + 4'h1;
            if (rxBitReg == PHS_BIT_LAST - 4'h1) begin
               rxArmReg    <= 1'b0;
               rxWordReg   <= rxShiftNext;
               rxWordValid <= 1'b1;
            end
         end
      end
   end
   assign rxWord = rxWordReg;
endmodule : phs_highway
`default_nettype wire

// [phs_pkg.sv]
package phs_pkg;
   // operating modes selected by the opMode pins
   typedef enum logic [1:0] {
      PHS_FIXED_RATE  = 2'h0,                          // fixed_rate_timing: master clock is the bit clock
      PHS_VAR_RATE    = 2'h1,                          // variable_rate_timing: separate bit clocks
      PHS_REDUNDANCY  = 2'h2,                          // on-line test: repeat previous word
      PHS_ANALOG_LOOP = 2'h3                           // on-line test: send back received word
   } phs_mode_t;

   localparam int          PHS_WORD_BITS    = 8;       // one companded code word per slot
   localparam int          PHS_FIFO_DEPTH   = 8;       // transmit words buffered
   localparam int          PHS_SYNC_BITS    = 7;       // pin inputs passing the synchroniser
   localparam int          PHS_STARTUP_FRM  = 3;       // frames before outputs are enabled
   localparam int          PHS_CLK_PERIOD_NS = 10;     // 100 MHz system clock
   localparam int          PHS_MCLK_STOP_NS = 2000;    // master clock silence counted as stopped
   localparam int          PHS_MCLK_STOP_CYC = PHS_MCLK_STOP_NS / PHS_CLK_PERIOD_NS;
   localparam logic [7:0]  PHS_IDLE_CODE    = 8'hFF;   // sent when no word is queued
   localparam logic [7:0]  PHS_WORD_RST     = 8'h00;
   localparam logic [3:0]  PHS_BIT_LAST     = 4'h8;    // bit counter value after the eighth bit
   localparam logic [1:0]  PHS_FRM_RST      = 2'h0;
   localparam logic [1:0]  PHS_FRM_DONE     = 2'h3;
   localparam logic [7:0]  PHS_STOP_CNT_MAX = 8'(PHS_MCLK_STOP_CYC);
   // bit positions in the synchroniser vector
   localparam int          PHS_S_MCLK = 0;
   localparam int          PHS_S_TCLK = 1;
   localparam int          PHS_S_TFS  = 2;
   localparam int          PHS_S_RCLK = 3;
   localparam int          PHS_S_RFS  = 4;
   localparam int          PHS_S_RDAT = 5;
   localparam int          PHS_S_SIG  = 6;
endpackage : phs_pkg

// [phs_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module phs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,        // system clock
   input  wire logic             reset_n,    // synchronous reset
   input  wire logic             clkEn,      // freezes all state when low
   input  wire logic [WIDTH-1:0] inData,     // write word
   input  wire logic             inValid,    // write request
   output logic                  inReady,    // not full
   output logic [WIDTH-1:0]      outData,    // head word
   output logic                  outValid,   // not empty
   input  wire logic             outReady    // pop request
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] memReg [DEPTH];
   logic [AW:0]      wrPtrReg;
   logic [AW:0]      rdPtrReg;
   wire              doWrite;
   wire              doRead;

   // full when pointers differ only in the wrap bit
   assign inReady  = !((wrPtrReg[AW] != rdPtrReg[AW]) && (wrPtrReg[AW-1:0] == rdPtrReg[AW-1:0]));
   assign outValid = (wrPtrReg != rdPtrReg);
   assign outData  = memReg[rdPtrReg[AW-1:0]];
   assign doWrite  = clkEn && inValid && inReady;
   assign doRead   = clkEn && outValid && outReady;

   // storage
   always_ff @(posedge clk) begin
      if (doWrite) begin
         memReg[wrPtrReg[AW-1:0]] <= inData;
      end
   end

   // pointers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wrPtrReg <= '0;
         rdPtrReg <= '0;
      end else begin
         if (doWrite) wrPtrReg <= wrPtrReg + 1'b1;
         if (doRead)  rdPtrReg <= rdPtrReg + 1'b1;
      end
   end
endmodule : phs_fifo
`default_nettype wire

// [phs_highway_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module phs_highway_asserts
   import phs_pkg::*;
(
   input wire logic      clk,               // clock
   input wire logic      reset_n,           // reset
   input wire phs_mode_t opMode,            // mode
   input wire logic      master_clock,      // master pin
   input wire logic      tx_bit_clock,      // bit clock pin
   input wire logic      sigOut,            // signaling out
   input wire logic      tx_pcm_data,       // tx data
   input wire logic      txDataOe,          // data enable
   input wire logic      tx_slot_indicator, // slot flag
   input wire logic      txSlotOe,          // flag enable
   input wire logic      outputsLive        // startup over
);
   wire logic  txClk = (opMode == PHS_FIXED_RATE) ? master_clock : tx_bit_clock;
   logic       clkQ, mclkQ;
   logic [3:0] riseCnt, sinceRise;
   logic [7:0] stillCnt;
   wire logic  rise = txClk && !clkQ;
   // pin edges, rises seen in the slot, quiet master clock time
   always_ff @(posedge clk) begin
      clkQ      <= txClk;
      mclkQ     <= master_clock;
      riseCnt   <= (!reset_n || !txDataOe) ? 4'h0 : riseCnt + 4'(rise);
      sinceRise <= (!reset_n || rise) ? 4'h0 : sinceRise + 4'(sinceRise != 4'hF);
      stillCnt  <= (!reset_n || master_clock != mclkQ) ? 8'h00 : stillCnt + 8'(stillCnt != 8'hFF);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_startup_dark: assert property (!outputsLive |-> !txDataOe && !txSlotOe)
      else $error("highway driven during startup");
   a_sig_low: assert property (!outputsLive && !$past(outputsLive) |-> !sigOut)
      else $error("signaling out high during startup");
   a_slot_flag: assert property (tx_slot_indicator == txDataOe)
      else $error("slot flag differs from data enable");
   a_flag_enable: assert property (txDataOe |-> txSlotOe)
      else $error("data driven with flag released");
   a_clock_stop: assert property (stillCnt >= 8'hE6 |-> !txSlotOe && !txDataOe)
      else $error("outputs driven with master clock stopped");
   a_eight_bits: assert property ($fell(txDataOe) && txSlotOe |-> riseCnt == 4'h8)
      else $error("slot length not eight bits");
   a_bit_steady: assert property (txDataOe && $past(txDataOe) && $changed(tx_pcm_data) |-> sinceRise <= 4'h6)
      else $error("data changed mid bit");
   a_first_bit: assert property ($rose(txDataOe) |-> sinceRise <= 4'h5)
      else $error("slot start not tied to bit clock rise");
endmodule : phs_highway_asserts
`default_nettype wire

// [phs_pcm_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module phs_pcm_partner (
   output logic      master_clock,  // master clock
   output logic      tx_bit_clock,  // tx bit clock
   output logic      tx_frame_sync, // tx sync
   output logic      rx_bit_clock,  // rx bit clock
   output logic      rx_frame_sync, // rx sync
   output logic      rx_pcm_data,   // rx highway
   input  wire logic fixedMode,     // one shared clock
   input  wire logic mclkRun,       // low stops master
   input  wire logic txLine,        // resolved tx highway
   input  wire logic txOe           // device drives
);
   logic bclkEn;
   // bit clocks pulse only inside a slot
   assign tx_bit_clock = bclkEn & master_clock;
   assign rx_bit_clock = bclkEn & master_clock;
   // master clock holds its level while stopped
   initial begin
      {master_clock, bclkEn, tx_frame_sync, rx_frame_sync} = 4'h0;
      rx_pcm_data = 1'b1;
      forever begin
         #40;
         if (mclkRun)
            master_clock = ~master_clock;
      end
   end
   // one slot: sync ahead of the first rise, nine rises, tx sampled late in each bit
   task automatic run_frame(input logic [7:0] rxByte, output logic [7:0] txByte, output int nOe);
      int i;
      nOe = 0;
      @(negedge master_clock);
      #3;
      {tx_frame_sync, rx_frame_sync} = 2'h3;
      for (i = 0; i < 9; i++) begin
         @(posedge master_clock);
         bclkEn = !fixedMode;
         rx_pcm_data = (i < 8) ? rxByte[7 - i] : ~rxByte[0];
         #73;
         {tx_frame_sync, rx_frame_sync} = 2'h0;
         if (i < 8)
            txByte[7 - i] = txLine;
         nOe += int'(txOe);
      end
      bclkEn = 1'b0;
   endtask : run_frame
endmodule : phs_pcm_partner
`default_nettype wire

// [phs_highway_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module phs_highway_tb_top
   import phs_pkg::*;
   ;
   logic       clk, reset_n, clkEn, standby, signaling_in, sigInsert, txWordValid, mclkRun;
   phs_mode_t  opMode;
   logic [7:0] txWord, lastTx, lastRx;
   wire logic  master_clock, tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync, rx_pcm_data;
   wire logic  sigOut, tx_pcm_data, txDataOe, tx_slot_indicator, txSlotOe, txWordReady, rxWordValid, outputsLive;
   wire logic [7:0] rxWord;
   wire logic  txLine = txDataOe ? tx_pcm_data : 1'b1; // pull-up on the released highway
   int         n_errors, samples_checked, i;
   logic [7:0] txExp[$], rxSeen[$];
   phs_highway u_phs_highway (.clk, .reset_n, .clkEn, .opMode, .standby, .master_clock, .tx_bit_clock,
      .tx_frame_sync, .rx_bit_clock, .rx_frame_sync, .rx_pcm_data, .signaling_in, .sigInsert, .sigOut,
      .tx_pcm_data, .txDataOe, .tx_slot_indicator, .txSlotOe, .txWord, .txWordValid, .txWordReady,
      .rxWord, .rxWordValid, .outputsLive);
   phs_pcm_partner u_phs_pcm_partner (.master_clock, .tx_bit_clock, .tx_frame_sync, .rx_bit_clock,
      .rx_frame_sync, .rx_pcm_data, .fixedMode(opMode == PHS_FIXED_RATE), .mclkRun, .txLine, .txOe(txDataOe));
   // clock and received word log
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (rxWordValid === 1'b1)
         rxSeen.push_back(rxWord);
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic push(input logic [7:0] w);
      int k;
      txWord <= w;
      txWordValid <= 1'b1;
      txExp.push_back(w);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (txWordReady !== 1'b1 && k < 50);
   endtask : push
   task automatic frame(input int expOe);
      logic [7:0] rb, tw, ew;
      int         n;
      @(posedge clk);
      rb = 8'($urandom);
      ew = (opMode == PHS_REDUNDANCY) ? lastTx : (opMode == PHS_ANALOG_LOOP) ? lastRx
         : (txExp.size() > 0) ? txExp.pop_front() : PHS_IDLE_CODE;
      if (expOe == 8 && sigInsert && signaling_in) ew[0] = 1'b1; // high signaling bit forces the LSB high
      u_phs_pcm_partner.run_frame(rb, tw, n);
      if (expOe >= 0) check("slot bits", 8'(expOe), 8'(n));
      if (expOe == 8) begin
         check("tx word", ew, tw);
         check("rx word", rb, (rxSeen.size() > 0) ? rxSeen.pop_front() : ~rb);
         lastTx = ew;
         lastRx = rb;
      end
   endtask : frame
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      void'($urandom(32'h7893));
      {reset_n, standby, sigInsert, txWordValid} <= 4'h0;
      {clkEn, mclkRun, signaling_in} <= 3'h7;
      opMode <= PHS_VAR_RATE;
      txWord <= 8'h00;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (i = 0; i < 3; i++) begin
         frame(i < 2 ? 0 : -1);
         if (i < 2) check("sigOut", 8'h00, 8'(sigOut));
      end
      check("outputsLive", 8'h01, 8'(outputsLive));
      rxSeen.delete();
      $display("done: startup");
      for (i = 0; i < 8; i++) push(8'($urandom));
      txWordValid <= 1'b0;
      repeat (2) @(posedge clk);
      check("txWordReady", 8'h00, 8'(txWordReady));
      for (i = 0; i < 9; i++) frame(8);
      check("sigOut", 8'h01, 8'(sigOut));
      $display("done: variable rate");
      opMode <= PHS_FIXED_RATE;
      sigInsert <= 1'b1;
      for (i = 0; i < 2; i++) push(8'($urandom));
      txWordValid <= 1'b0;
      for (i = 0; i < 2; i++) frame(8);
      sigInsert <= 1'b0;
      signaling_in <= 1'b0;
      repeat (4) @(posedge clk);
      check("sigOut", 8'h00, 8'(sigOut));
      $display("done: fixed rate");
      opMode <= PHS_REDUNDANCY;
      for (i = 0; i < 4; i++) begin
         if (i == 2) opMode <= PHS_ANALOG_LOOP;
         frame(8);
      end
      $display("done: on-line tests");
      opMode <= PHS_VAR_RATE;
      mclkRun <= 1'b0;
      repeat (250) @(posedge clk);
      check("txSlotOe", 8'h00, 8'(txSlotOe));
      mclkRun <= 1'b1;
      frame(8);
      $display("done: clock stop");
      standby <= 1'b1;
      repeat (4) @(posedge clk);
      check("outputsLive", 8'h00, 8'(outputsLive));
      standby <= 1'b0;
      frame(0);
      $display("done: standby");
      print_verdict();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule : phs_highway_tb_top
bind phs_highway phs_highway_asserts u_phs_highway_asserts (.clk, .reset_n, .opMode, .master_clock,
   .tx_bit_clock, .sigOut, .tx_pcm_data, .txDataOe, .tx_slot_indicator, .txSlotOe, .outputsLive);
`default_nettype wire
